// >>> rtl/sac_pkg.sv
// Constants shared by both ends of the converter control link.
//
// How it works
// - Result drives a twelve bit parallel port.
// - Data drivers on only with select and read low.
// - Data lines float when select or read rises.
// - Tied-low strobes show result before busy falls.
// - Host never reads while busy is high.
// - Host may keep select low permanently.
// - Start strobe falling edge samples and starts conversion.
// - High-speed host raises start before busy falls.
// - Repeated start edge during busy restarts conversion.
// - Host waits 135 ns after busy falls.
// - Start low at busy fall enters sleep.
// - Depth select high partial, low full sleep.
// - Start strobe rising edge begins wake-up.
// - Wake-up lasts 1 us partial, 500 us full.
// - Start during wake-up deferred until wake-up ends.
// - Busy stays high for 810 ns conversion.
// - Sleep stops oscillator and comparator; full sleep also stops the reference, partial sleep puts its buffer in low power.
// - Host discards one dummy conversion after power-up.
// - Busy rises at start, falls at completion.
// - Result coded as straight unsigned binary.
package sac_pkg;

  localparam int unsigned DATA_W          = 12;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned FIFO_DEPTH      = 4;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CONV_TIME_NS    = 810;
  localparam int unsigned WAKE_PART_NS    = 1000;
  localparam int unsigned WAKE_FULL_NS    = 500000;
  localparam int unsigned ACQ_TIME_NS     = 135;

  localparam int unsigned CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_PART_CYC   = (WAKE_PART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_FULL_CYC   = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACQ_CYC         = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Exactly covers the host strobe flop, the device input filter and the host data filter, with no cycle to spare.
  localparam int unsigned READ_CYC        = 10;

  // Pin vector order on the device: start, select, read, depth select.
  localparam logic [3:0]  DEV_PIN_RESET   = 4'hE;
  localparam int unsigned PIN_START       = 3;
  localparam int unsigned PIN_SELECT      = 2;
  localparam int unsigned PIN_READ        = 1;
  localparam int unsigned PIN_DEPTH       = 0;
  localparam logic [DATA_W-1:0] RESULT_RESET = 12'h000;

  typedef enum logic [1:0] {
    ST_AWAKE = 2'h0,
    ST_CONV  = 2'h1,
    ST_SLEEP = 2'h3,
    ST_WAKE  = 2'h2
  } sac_dev_state_t;

  typedef enum logic [2:0] {
    HS_ACQ     = 3'h0,
    HS_START   = 3'h1,
    HS_WAIT_HI = 3'h3,
    HS_WAIT_LO = 3'h2,
    HS_READ    = 3'h6
  } sac_host_state_t;

endpackage : sac_pkg

// >>> rtl/sac_link_if.sv
// Pin-level link between the converter and its host.
`timescale 1ns/100ps
`default_nettype none
interface sac_link_if
  import sac_pkg::*;
();
  logic              conversion_start_n;
  logic              busy;
  logic              cs_n;
  logic              rd_n;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  logic [DATA_W-1:0] data_bus;

  // Undriven, the bus shows the inverted result, so a read taken too early is caught.
  assign data_bus = data_oe ? data_out : ~data_out;

  modport dev (
    input  conversion_start_n,
    input  cs_n,
    input  rd_n,
    output busy,
    output data_out,
    output data_oe
  );

  modport host (
    output conversion_start_n,
    output cs_n,
    output rd_n,
    input  busy,
    input  data_bus
  );
endinterface : sac_link_if
`default_nettype wire

// >>> rtl/sac_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module sac_fifo
  import sac_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule : sac_fifo
`default_nettype wire

// >>> rtl/sac_device.sv
// Converter end: conversion timing, sleep control and parallel read port.
`timescale 1ns/100ps
`default_nettype none
module sac_device
  import sac_pkg::*;
#(
  parameter int unsigned WAKE_FULL_CYCLES = WAKE_FULL_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Link to the host
  sac_link_if.dev                link,
  // Converter core
  input  wire logic [DATA_W-1:0] sample_code,
  input  wire logic              sleep_depth_select,
  // Power control of the analog blocks
  output logic                   osc_run,
  output logic                   comparator_on,
  output logic                   reference_on,
  output logic                   ref_buffer_low_power
);

  logic [3:0]        sync1_reg;
  logic [3:0]        sync2_reg;
  logic [3:0]        sync3_reg;
  logic [3:0]        pin_reg;
  logic              start_prev_reg;
  logic              start_level;
  logic              start_fall;
  logic              start_rise;

  sac_dev_state_t    state_reg;
  sac_dev_state_t    state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  wake_last;
  logic              conv_done;
  logic              wake_done;
  logic              pending_reg;
  logic              sleep_partial_reg;
  logic              busy_reg;
  logic [DATA_W-1:0] held_code_reg;
  logic [DATA_W-1:0] result_reg;

  // Pins pass three flops; a level is taken only once the last two agree.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= DEV_PIN_RESET;
      sync2_reg <= DEV_PIN_RESET;
      sync3_reg <= DEV_PIN_RESET;
      pin_reg   <= DEV_PIN_RESET;
    end
    else
    begin
      sync1_reg <= {link.conversion_start_n, link.cs_n, link.rd_n, sleep_depth_select};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg ^ sync3_reg));
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_prev_reg <= 1'h1;
    end
    else
    begin
      start_prev_reg <= pin_reg[PIN_START];
    end
  end

  assign start_level = pin_reg[PIN_START];
  assign start_fall  = start_prev_reg & ~start_level;
  assign start_rise  = ~start_prev_reg & start_level;

  assign conv_done = cnt_reg == CNT_W'(CONV_CYC - 1);
  assign wake_last = sleep_partial_reg ? CNT_W'(WAKE_PART_CYC - 1)
                                       : CNT_W'(WAKE_FULL_CYCLES - 1);
  assign wake_done = cnt_reg == wake_last;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_AWAKE:
      begin
        if (start_fall)
        begin
          state_next = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (start_fall)
        begin
          state_next = ST_CONV;
        end
        else if (conv_done)
        begin
          // Start level at the busy fall decides between sleep and awake.
          state_next = start_level ? ST_AWAKE : ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (start_rise)
        begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (wake_done)
        begin
          state_next = (pending_reg | start_fall) ? ST_CONV : ST_AWAKE;
        end
      end
      default:
      begin
        state_next = ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_AWAKE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // A restart clears the count, so the full conversion time runs again.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
    end
    else if (state_next != state_reg || (state_reg == ST_CONV && start_fall))
    begin
      cnt_reg <= '0;
    end
    else if (state_reg == ST_CONV || state_reg == ST_WAKE)
    begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // A start edge seen while waking is remembered until the wake-up ends.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pending_reg <= 1'h0;
    end
    else if (state_reg != ST_WAKE)
    begin
      pending_reg <= 1'h0;
    end
    else if (start_fall)
    begin
      pending_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_partial_reg <= 1'h1;
    end
    else if (state_reg == ST_CONV && state_next == ST_SLEEP)
    begin
      sleep_partial_reg <= pin_reg[PIN_DEPTH];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_reg <= 1'h0;
    end
    else
    begin
      busy_reg <= state_next == ST_CONV;
    end
  end

  // The input is held when a conversion starts or restarts, at the wake-up end for a deferred start; the code is straight binary.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      held_code_reg <= RESULT_RESET;
    end
    else if (state_next == ST_CONV && (state_reg != ST_CONV || start_fall))
    begin
      held_code_reg <= sample_code;
    end
  end

  // Latched one cycle before busy falls so a tied-low reader sees it first.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_reg <= RESULT_RESET;
    end
    else if (state_reg == ST_CONV && !start_fall && cnt_reg == CNT_W'(CONV_CYC - 2))
    begin
      result_reg <= held_code_reg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_run              <= 1'h1;
      comparator_on        <= 1'h1;
      reference_on         <= 1'h1;
      ref_buffer_low_power <= 1'h0;
    end
    else
    begin
      osc_run              <= state_next != ST_SLEEP;
      comparator_on        <= state_next != ST_SLEEP;
      reference_on         <= !(state_next == ST_SLEEP && !sleep_partial_reg);
      ref_buffer_low_power <= state_next == ST_SLEEP && sleep_partial_reg;
    end
  end

  assign link.busy     = busy_reg;
  assign link.data_out = result_reg;
  // The strobes are filtered, so the drivers follow them a few cycles late.
  assign link.data_oe  = ~pin_reg[PIN_SELECT] & ~pin_reg[PIN_READ];

endmodule : sac_device
`default_nettype wire

// >>> rtl/sac_host.sv
// Host end: starts conversions, reads results and queues them.
`timescale 1ns/100ps
`default_nettype none
module sac_host
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Link to the converter
  sac_link_if.host               link,
  // Control
  input  wire logic              run,
  input  wire logic              sleep_mode,
  input  wire logic              cs_hold,
  // Result stream
  output logic                   sample_valid,
  input  wire logic              sample_ready,
  output logic [DATA_W-1:0]      sample_data
);

  logic [DATA_W:0]   sync1_reg;
  logic [DATA_W:0]   sync2_reg;
  logic [DATA_W:0]   sync3_reg;
  logic [DATA_W:0]   pin_reg;
  logic              busy_level;
  sac_host_state_t   state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              mode_reg;
  logic              dummy_reg;
  logic              start_n_reg;
  logic              read_n_reg;
  logic              push_reg;
  logic [DATA_W-1:0] cap_reg;
  logic              fifo_in_ready;
  logic              read_end;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg   <= '0;
    end
    else
    begin
      sync1_reg <= {link.busy, link.data_bus};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign busy_level = pin_reg[DATA_W];
  assign read_end   = state_reg == HS_READ && cnt_reg == CNT_W'(READ_CYC - 1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= HS_ACQ;
      cnt_reg   <= '0;
      mode_reg  <= 1'h0;
    end
    else
    begin
      cnt_reg <= cnt_reg + CNT_W'(cnt_reg != '1);
      case (state_reg)
        HS_ACQ:
        begin
          // Back-pressure: no conversion starts without room for its result.
          if (cnt_reg >= CNT_W'(ACQ_CYC - 1) && run && fifo_in_ready)
          begin
            state_reg <= HS_START;
            mode_reg  <= sleep_mode;
          end
        end
        HS_START:
        begin
          state_reg <= HS_WAIT_HI;
        end
        HS_WAIT_HI:
        begin
          // Waits out any wake-up, however long it is.
          if (busy_level)
          begin
            state_reg <= HS_WAIT_LO;
          end
        end
        HS_WAIT_LO:
        begin
          if (!busy_level)
          begin
            state_reg <= HS_READ;
            cnt_reg   <= '0;
          end
        end
        HS_READ:
        begin
          if (read_end)
          begin
            state_reg <= HS_ACQ;
            cnt_reg   <= '0;
          end
        end
        default:
        begin
          state_reg <= HS_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_n_reg <= 1'h1;
      read_n_reg  <= 1'h1;
    end
    else
    begin
      // High-speed mode raises start once busy is seen; sleep mode after the read.
      start_n_reg <= !(state_reg == HS_START || state_reg == HS_WAIT_HI
                       || (mode_reg && state_reg == HS_WAIT_LO)
                       || (mode_reg && state_reg == HS_READ && !read_end));
      read_n_reg  <= !(state_reg == HS_READ && !read_end);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dummy_reg <= 1'h1;
      push_reg  <= 1'h0;
      cap_reg   <= RESULT_RESET;
    end
    else
    begin
      push_reg <= read_end && !dummy_reg;
      if (read_end)
      begin
        cap_reg   <= pin_reg[DATA_W-1:0];
        dummy_reg <= 1'h0;
      end
    end
  end

  assign link.conversion_start_n = start_n_reg;
  assign link.rd_n               = read_n_reg;
  assign link.cs_n               = read_n_reg & ~cs_hold;

  sac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_reg),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

endmodule : sac_host
`default_nettype wire

// >>> testbench/sac_link_monitor.sv
// Concurrent checks on the link between the converter end and the host end.
`timescale 1ns/100ps
`default_nettype none
module sac_link_monitor
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Link signals
  input wire logic              conversion_start_n,
  input wire logic              busy,
  input wire logic              cs_n,
  input wire logic              rd_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic [DATA_W-1:0] data_bus
);
  logic [7:0] busy_cnt_reg;
  logic [7:0] idle_cnt_reg;

  // The host on this link never restarts, so every busy period is one full conversion.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_cnt_reg <= 8'h00;
    else if (busy)
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    else
      busy_cnt_reg <= 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idle_cnt_reg <= 8'h00;
    else if (busy)
      idle_cnt_reg <= 8'h00;
    else if (idle_cnt_reg != 8'hFF)
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
  end

  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);

  busy_width_a: assert property ($fell(busy) |-> busy_cnt_reg == 8'h51)
    else $error("busy high time differs from the conversion time");
  busy_cap_a: assert property (busy_cnt_reg <= 8'h51)
    else $error("busy stays high past the conversion time");
  busy_start_a: assert property ($rose(busy) |-> !conversion_start_n && !$past(conversion_start_n, 3))
    else $error("busy rose without a start strobe");
  acq_gap_a: assert property ($fell(conversion_start_n) |-> idle_cnt_reg >= 8'h0E)
    else $error("start came too soon after busy fell");
  oe_cause_a: assert property ($rose(data_oe) |-> !$past(cs_n) && !$past(rd_n))
    else $error("data drivers enabled without select and read");
  oe_release_a: assert property ((cs_n || rd_n) [*6] |-> !data_oe)
    else $error("data drivers still on after a strobe rose");
  no_busy_read_a: assert property (data_oe |-> !busy)
    else $error("read while a conversion runs");
  bus_drive_a: assert property (data_oe |-> data_bus == data_out)
    else $error("data bus does not carry the result");
  result_hold_a: assert property ($changed(data_out) |-> busy)
    else $error("result changed outside a conversion");

  cover property ($fell(busy));
  cover property ($rose(data_oe));
  cover property ($rose(conversion_start_n) && !busy);
endmodule : sac_link_monitor
`default_nettype wire

// >>> testbench/testbench.sv
// Testbench: host and converter ends joined, plus a converter driven by the bench.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sac_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              run = 1'b0;
  logic              sleep_mode = 1'b0;
  logic              cs_hold = 1'b0;
  logic              sample_ready = 1'b0;
  logic              depth = 1'b1;
  logic              sample_valid;
  logic [DATA_W-1:0] sample_data;
  logic [DATA_W-1:0] code1 = 12'h100;
  logic [DATA_W-1:0] code2 = 12'h000;
  logic [3:0]        pwr;
  logic              busy_q = 1'b0;
  int                fails = 0;
  int                tests_run = 0;
  int                rises = 0;
  int                n;

  sac_link_if u_sac_link_if ();
  sac_link_if u_sac_link_if_2 ();

  sac_device #(.WAKE_FULL_CYCLES(200)) u_sac_device (.clk(clk), .rst(rst),
    .link(u_sac_link_if), .sample_code(code1), .sleep_depth_select(depth),
    .osc_run(pwr[3]), .comparator_on(pwr[2]), .reference_on(pwr[1]),
    .ref_buffer_low_power(pwr[0]));
  sac_device #(.WAKE_FULL_CYCLES(200)) u_sac_device_2 (.clk(clk), .rst(rst),
    .link(u_sac_link_if_2), .sample_code(code2), .sleep_depth_select(1'b1),
    .osc_run(), .comparator_on(), .reference_on(), .ref_buffer_low_power());
  sac_host u_sac_host (.clk(clk), .rst(rst), .link(u_sac_link_if), .run(run),
    .sleep_mode(sleep_mode), .cs_hold(cs_hold), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));
  sac_link_monitor u_sac_link_monitor (.clk(clk), .rst(rst),
    .conversion_start_n(u_sac_link_if.conversion_start_n), .busy(u_sac_link_if.busy),
    .cs_n(u_sac_link_if.cs_n), .rd_n(u_sac_link_if.rd_n),
    .data_out(u_sac_link_if.data_out), .data_oe(u_sac_link_if.data_oe),
    .data_bus(u_sac_link_if.data_bus));

  always #5 clk = ~clk;

  // A fresh input code per conversion lets the queued words be told apart.
  always @(posedge clk)
  begin
    busy_q <= u_sac_link_if.busy;
    if (busy_q && !u_sac_link_if.busy)
      code1 <= code1 + 12'h001;
    if (!busy_q && u_sac_link_if.busy)
      rises <= rises + 1;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  function automatic logic sig(input int sel);
    case (sel)
      0: return u_sac_link_if.busy;
      1: return u_sac_link_if_2.busy;
      2: return u_sac_link_if.conversion_start_n;
      default: return sample_valid;
    endcase
  endfunction : sig

  // Bounded wait; the cycle count is left in n for timing checks.
  task automatic wait_lvl(input int sel, input logic lvl);
    n = 0;
    while (sig(sel) !== lvl && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      check(16'h0000, 16'h0001);
  endtask : wait_lvl

  task automatic pop(input logic [DATA_W-1:0] exp);
    wait_lvl(3, 1'b1);
    check(sample_data, exp);
    sample_ready <= 1'b1;
    tick(1);
    sample_ready <= 1'b0;
    tick(1);
  endtask : pop

  initial
  begin
    u_sac_link_if_2.conversion_start_n <= 1'b1;
    u_sac_link_if_2.cs_n <= 1'b1;
    u_sac_link_if_2.rd_n <= 1'b1;
    tick(12);
    rst <= 1'b0;
    tick(1);
    check(u_sac_link_if.busy, 1'b0);
    check(u_sac_link_if.data_oe, 1'b0);
    check(pwr, 4'hE);
    $display("test reset done");
    run <= 1'b1;
    tick(1500);
    check(rises[15:0], 16'h0005);
    run <= 1'b0;
    for (int i = 1; i < 5; i++)
      pop(12'h100 + i[11:0]);
    check(sample_valid, 1'b0);
    $display("test queue done");
    sleep_mode <= 1'b1;
    cs_hold <= 1'b1;
    sample_ready <= 1'b1;
    run <= 1'b1;
    for (int d = 1; d >= 0; d--)
    begin
      int lo;
      lo = (d == 1) ? 100 : 200;
      depth <= d[0];
      tick(1);
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      tick(3);
      check(pwr, {2'b00, d[0], d[0]});
      wait_lvl(2, 1'b1);
      wait_lvl(0, 1'b1);
      check((n >= lo) && (n <= lo + 15), 1'b1);
      check(pwr, 4'hE);
    end
    run <= 1'b0;
    $display("test sleep done");
    u_sac_link_if_2.conversion_start_n <= 1'b0;
    code2 <= 12'hA5A;
    wait_lvl(1, 1'b1);
    tick(20);
    u_sac_link_if_2.conversion_start_n <= 1'b1;
    tick(8);
    code2 <= 12'h5C3;
    u_sac_link_if_2.conversion_start_n <= 1'b0;
    tick(10);
    u_sac_link_if_2.conversion_start_n <= 1'b1;
    wait_lvl(1, 1'b0);
    check((n > 70) && (n < 82), 1'b1);
    u_sac_link_if_2.rd_n <= 1'b0;
    tick(8);
    check(u_sac_link_if_2.data_oe, 1'b0);
    u_sac_link_if_2.cs_n <= 1'b0;
    tick(8);
    check({u_sac_link_if_2.data_oe, u_sac_link_if_2.data_bus}, {1'b1, 12'h5C3});
    u_sac_link_if_2.rd_n <= 1'b1;
    tick(8);
    check(u_sac_link_if_2.data_oe, 1'b0);
    u_sac_link_if_2.rd_n <= 1'b0;
    code2 <= 12'h3E1;
    u_sac_link_if_2.conversion_start_n <= 1'b0;
    wait_lvl(1, 1'b1);
    u_sac_link_if_2.conversion_start_n <= 1'b1;
    wait_lvl(1, 1'b0);
    check(u_sac_link_if_2.data_bus, 12'h3E1);
    $display("test direct link done");
    close_out();
  end

  initial
  begin
    tick(20000);
    fails++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
